// ===== pkg/tx_seq_cfg.svh
/*
 * Constants of the transmit enable timing sequencer: register offsets,
 * field positions, reset values and analog timing counts.
 * Assumes a 100 MHz core clock and a 32-bit classic Wishbone slave port.
 */
`ifndef TX_SEQ_CFG_SVH
`define TX_SEQ_CFG_SVH

`define CLK_MHZ 100
`define SETUP_NORETUNE_US 8
`define SETUP_RETUNE_US 758
`define TUNE_US 750
`define SETUP_NORETUNE_CYC (`SETUP_NORETUNE_US * `CLK_MHZ)
`define SETUP_RETUNE_CYC (`SETUP_RETUNE_US * `CLK_MHZ)

`define OFS_CTRL 8'h00
`define OFS_RISE_ANT 8'h04
`define OFS_RISE_PWR 8'h08
`define OFS_GUARD 8'h0C
`define OFS_HOLD 8'h10
`define OFS_FALL_OFF 8'h14
`define OFS_STATUS 8'h18

`define CTRL_RETUNE_BIT 0
`define CTRL_ANT_OWN_BIT 1
`define CTRL_RESET 32'h0000_0002
`define DELAY_RESET 32'h0000_0000

`define ST_ENABLE_BIT 0
`define ST_IFACE_BIT 1
`define ST_PWR_BIT 2
`define ST_READY_BIT 3
`define ST_ANT_BIT 4
`define ST_STATE_LSB 8

`endif

// ===== pkg/tx_seq_pkg.sv
/*
 * Types of the transmit enable timing sequencer.
 * Assumes nothing beyond the cfg header for constants.
 */
package tx_seq_pkg;
    typedef enum logic [2:0] {
        seq_idle,
        seq_rising,
        seq_on,
        seq_falling
    } seq_state_t;
endpackage

// ===== sim/baseband_model.sv
/*
 * Baseband partner: drives the transmit-enable pin and derives the
 * programmed delays from a path latency that it keeps to itself.
 * Assumes the bench calls its tasks at rising edges of core_clk.
 */
`timescale 1ns/1ps
module baseband_model (
    input wire logic core_clk,
    output logic tx_enable_pin
);
    initial tx_enable_pin = 1'b0;

    // Callers hold each level for at least 3 cycles so the synchroniser sees it
    task automatic drive(input logic v);
        @(posedge core_clk);
        tx_enable_pin <= v;
    endtask

    // Latency stays on this side; only the derived delays are written
    task automatic plan(input int lat, input int setup, output int da, output int dp,
        output int doff);
        da = lat;
        dp = (lat > setup) ? lat - setup : 0;
        doff = lat;
    endtask
endmodule

// ===== sim/testbench.sv
/*
 * Self-checking bench of the transmit enable timing sequencer.
 * Assumes a classic Wishbone slave acking one cycle after the taking edge.
 */
`timescale 1ns/1ps
`include "tx_seq_cfg.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, (a), (b)); end end
module testbench;
    localparam int S_NO = 4;
    localparam int S_RT = 20;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic tx_enable_pin;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic tx_iface_en;
    logic analog_power_en;
    logic analog_ready;
    logic antenna_tx_sel;
    int cyc = 0;
    int n_fail = 0;
    int samples_checked = 0;
    int t_up[4];
    int t_dn[4];
    logic [3:0] o_old = 4'h0;
    wire [3:0] o = {analog_ready, antenna_tx_sel, analog_power_en, tx_iface_en};

    tx_enable_timing_sequencer #(.SETUP_NORETUNE(S_NO), .SETUP_RETUNE(S_RT))
        tx_enable_timing_sequencer_inst (
        .core_clk(core_clk), .reset(reset), .clk_en(clk_en),
        .tx_enable_pin(tx_enable_pin), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .tx_iface_en(tx_iface_en), .analog_power_en(analog_power_en),
        .analog_ready(analog_ready), .antenna_tx_sel(antenna_tx_sel)
    );
    baseband_model baseband_model_inst (.core_clk(core_clk), .tx_enable_pin(tx_enable_pin));

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Edge times of each output, in edges counted after settling
    always @(posedge core_clk) begin
        #1;
        cyc = cyc + 1;
        for (int i = 0; i < 4; i++) begin
            if (o[i] === 1'b1 && o_old[i] !== 1'b1) t_up[i] = cyc;
            if (o[i] === 1'b0 && o_old[i] === 1'b1) t_dn[i] = cyc;
        end
        o_old = o;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= wd;
        wb_sel_i <= 4'hF;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n == 50) n_fail++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        wb(1'b1, a, d, x);
    endtask

    task automatic t_reset();
        logic [31:0] r;
        `CHK(o, 4'h0)
        wb(1'b0, `OFS_CTRL, 32'h0, r);
        `CHK(r, `CTRL_RESET)
        wb(1'b0, `OFS_FALL_OFF, 32'h0, r);
        `CHK(r, `DELAY_RESET)
        wr(`OFS_RISE_ANT, 32'h0000_005A);
        wb(1'b0, `OFS_RISE_ANT, 32'h0, r);
        `CHK(r, 32'h0000_005A)
        wr(`OFS_HOLD, 32'h0000_0007);
        wb(1'b0, `OFS_HOLD, 32'h0, r);
        `CHK(r, 32'h0)
        wb(1'b0, 8'hFC, 32'h0, r);
        `CHK(r, 32'h0)
    endtask

    task automatic burst(input int lat, input logic rt, input logic own);
        int da, dp, doff, s, t0, t1, au, ad;
        logic [31:0] r;
        s = rt ? S_RT : S_NO;
        baseband_model_inst.plan(lat, s, da, dp, doff);
        wr(`OFS_CTRL, {30'h0, own, rt});
        wr(`OFS_RISE_ANT, da);
        wr(`OFS_RISE_PWR, dp);
        wr(`OFS_GUARD, 32'h0);
        wr(`OFS_FALL_OFF, doff);
        au = t_up[2];
        ad = t_dn[2];
        baseband_model_inst.drive(1'b1);
        t0 = cyc + 1;
        repeat (da + dp + s + 8) @(posedge core_clk);
        `CHK(t_up[0], t0 + 3)
        `CHK(t_up[1], t0 + 3 + dp)
        `CHK(t_up[3], t0 + 3 + dp + s)
        `CHK(t_up[2], own ? t0 + 3 + da : au)
        wb(1'b0, `OFS_STATUS, 32'h0, r);
        `CHK(r, 32'h0000_020F | (32'(own) << `ST_ANT_BIT))
        baseband_model_inst.drive(1'b0);
        t1 = cyc + 1;
        repeat (doff + 8) @(posedge core_clk);
        `CHK(t_dn[0], t1 + 3)
        `CHK(t_dn[1], t1 + 4 + doff)
        `CHK(t_dn[2], own ? t1 + 3 + doff : ad)
        `CHK(t_dn[0] < t_dn[1], 1'b1)
        `CHK(!own || t_dn[2] < t_dn[1], 1'b1)
    endtask

    // Enable drops while both rise timers still run; neither may fire late
    task automatic t_abort();
        int au, pu;
        wr(`OFS_CTRL, 32'h0000_0002);
        wr(`OFS_RISE_ANT, 32'd30);
        wr(`OFS_RISE_PWR, 32'd20);
        wr(`OFS_FALL_OFF, 32'd0);
        au = t_up[2];
        pu = t_up[1];
        baseband_model_inst.drive(1'b1);
        repeat (6) @(posedge core_clk);
        baseband_model_inst.drive(1'b0);
        repeat (40) @(posedge core_clk);
        `CHK(t_up[2], au)
        `CHK(t_up[1], pu)
        `CHK(o, 4'h0)
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        t_reset();
        burst(0, 1'b0, 1'b1);
        burst(30, 1'b1, 1'b1);
        burst(3, 1'b0, 1'b0);
        t_abort();
        give_verdict();
    end
endmodule

// ===== src/delay_timer.sv
/*
 * Single delay counter: loaded on start, pulses done at terminal count.
 * Assumes start is a one-cycle pulse on core_clk; a zero delay fires at once.
 */
`timescale 1ns/1ps
module delay_timer #(
    parameter int WIDTH = 32
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic start,
    input wire logic abort,
    input wire logic [WIDTH-1:0] delay,
    output logic done
);
    logic [WIDTH-1:0] count;
    logic running;

    // Zero delay fires combinationally with start so 0 really is 0 cycles
    // An abort in the terminal cycle wins, so a cancelled count never acts
    assign done = clk_en && ((start && delay == '0) ||
                             (running && !start && !abort && count == '0));

    always_ff @(posedge core_clk) begin
        if (reset) begin
            running <= 1'b0;
            count <= '0;
        end else if (clk_en) begin
            if (abort) begin
                running <= 1'b0;
            end else if (start) begin
                running <= (delay != '0);
                count <= delay - 1'b1;
            end else if (running) begin
                if (count == '0) begin
                    running <= 1'b0;
                end else begin
                    count <= count - 1'b1;
                end
            end
        end
    end
endmodule

// ===== src/pin_sync.sv
/*
 * Two-flop synchroniser with rising and falling edge pulses taken after it.
 * Assumes the pin is asynchronous to core_clk.
 */
`timescale 1ns/1ps
module pin_sync (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else if (clk_en) begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level = sync;
    assign rise = clk_en && sync && !prev;
    assign fall = clk_en && !sync && prev;
endmodule

// ===== src/tx_enable_timing_sequencer.sv
/*
 * Transmit enable timing sequencer: from the transmit-enable pin and the
 * programmed delays it drives interface enable, analog power and antenna.
 * Assumes a 100 MHz core_clk, synchronous active-high reset, and a classic
 * Wishbone master; the enable pin is asynchronous.
 */
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "tx_seq_cfg.svh"
module tx_enable_timing_sequencer
    import tx_seq_pkg::*;
#(
    parameter int DW = 32,
    parameter int SETUP_NORETUNE = `SETUP_NORETUNE_CYC,
    parameter int SETUP_RETUNE = `SETUP_RETUNE_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic tx_enable_pin,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic tx_iface_en,
    output logic analog_power_en,
    output logic analog_ready,
    output logic antenna_tx_sel
);
    logic [31:0] ctrl;
    logic [DW-1:0] rise_to_antenna_delay;
    logic [DW-1:0] rise_to_power_delay;
    logic [DW-1:0] leading_guard_time;
    logic [DW-1:0] fall_to_shutdown_delay;
    logic en_level;
    logic en_rise;
    logic en_fall;
    logic ant_done;
    logic pwr_done;
    logic off_done;
    logic setup_done;
    logic setup_start;
    logic [DW-1:0] setup_cycles;
    seq_state_t state;
    logic ant_owned;
    logic bus_req;
    logic [31:0] next_rdata;

    assign ant_owned = ctrl[`CTRL_ANT_OWN_BIT];
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Byte-lane merge for write data
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    pin_sync u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .pin(tx_enable_pin),
        .level(en_level),
        .rise(en_rise),
        .fall(en_fall)
    );

    delay_timer #(.WIDTH(DW)) u_ant (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .start(en_rise),
        .abort(en_fall),
        .delay(rise_to_antenna_delay),
        .done(ant_done)
    );

    delay_timer #(.WIDTH(DW)) u_pwr (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .start(en_rise),
        .abort(en_fall),
        .delay(rise_to_power_delay),
        .done(pwr_done)
    );

    delay_timer #(.WIDTH(DW)) u_off (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .start(en_fall),
        .abort(en_rise),
        .delay(fall_to_shutdown_delay),
        .done(off_done)
    );

    // Setup time depends on whether a synthesizer retune is needed
    assign setup_cycles = ctrl[`CTRL_RETUNE_BIT] ? DW'(SETUP_RETUNE) : DW'(SETUP_NORETUNE);
    assign setup_start = pwr_done;

    delay_timer #(.WIDTH(DW)) u_setup (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .start(setup_start),
        .abort(off_done),
        .delay(setup_cycles),
        .done(setup_done)
    );

    // Sequencer state for status visibility
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= seq_idle;
        end else if (clk_en) begin
            unique case (state)
                seq_idle: begin
                    if (en_rise) begin
                        state <= seq_rising;
                    end
                end
                seq_rising: begin
                    if (en_fall) begin
                        state <= seq_falling;
                    end else if ((antenna_tx_sel || !ant_owned) && analog_ready) begin
                        state <= seq_on;
                    end
                end
                seq_on: begin
                    if (en_fall) begin
                        state <= seq_falling;
                    end
                end
                seq_falling: begin
                    if (en_rise) begin
                        state <= seq_rising;
                    end else if (off_done) begin
                        state <= seq_idle;
                    end
                end
                default: state <= seq_idle;
            endcase
        end
    end

    // Hold time is forced to zero: interface follows the enable edges directly
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_iface_en <= 1'b0;
        end else if (clk_en) begin
            if (en_rise) begin
                tx_iface_en <= 1'b1;
            end else if (en_fall) begin
                tx_iface_en <= 1'b0;
            end
        end
    end

    // Power drops one edge after the off event, so interface and antenna are
    // already away from transmit even when both delays are zero
    logic pwr_drop_pending;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pwr_drop_pending <= 1'b0;
        end else if (clk_en) begin
            pwr_drop_pending <= off_done && !en_level;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            analog_power_en <= 1'b0;
        end else if (clk_en) begin
            if (pwr_done) begin
                analog_power_en <= 1'b1;
            end else if (pwr_drop_pending && !en_level) begin
                analog_power_en <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            analog_ready <= 1'b0;
        end else if (clk_en) begin
            if (setup_done) begin
                analog_ready <= 1'b1;
            end else if (off_done || en_fall) begin
                analog_ready <= 1'b0;
            end
        end
    end

    // Antenna returns on the same off event but one edge before power drops:
    // power is low only after antenna already reads low
    logic ant_drop_pending;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            antenna_tx_sel <= 1'b0;
        end else if (clk_en) begin
            if (ant_done && ant_owned) begin
                antenna_tx_sel <= 1'b1;
            end else if (ant_drop_pending || !ant_owned) begin
                antenna_tx_sel <= 1'b0;
            end
        end
    end
    // Antenna must leave on the off event, one edge ahead of the power drop
    assign ant_drop_pending = off_done && !en_level;

    // Wishbone registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl <= `CTRL_RESET;
            rise_to_antenna_delay <= DW'(`DELAY_RESET);
            rise_to_power_delay <= DW'(`DELAY_RESET);
            leading_guard_time <= DW'(`DELAY_RESET);
            fall_to_shutdown_delay <= DW'(`DELAY_RESET);
        end else if (clk_en && bus_req && wb_we_i) begin
            unique case (wb_adr_i)
                `OFS_CTRL: ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
                `OFS_RISE_ANT: rise_to_antenna_delay <=
                    DW'(merge(32'(rise_to_antenna_delay), wb_dat_i, wb_sel_i));
                `OFS_RISE_PWR: rise_to_power_delay <=
                    DW'(merge(32'(rise_to_power_delay), wb_dat_i, wb_sel_i));
                `OFS_GUARD: leading_guard_time <=
                    DW'(merge(32'(leading_guard_time), wb_dat_i, wb_sel_i));
                `OFS_FALL_OFF: fall_to_shutdown_delay <=
                    DW'(merge(32'(fall_to_shutdown_delay), wb_dat_i, wb_sel_i));
                default: ;
            endcase
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            `OFS_CTRL: next_rdata = ctrl;
            `OFS_RISE_ANT: next_rdata = 32'(rise_to_antenna_delay);
            `OFS_RISE_PWR: next_rdata = 32'(rise_to_power_delay);
            `OFS_GUARD: next_rdata = 32'(leading_guard_time);
            `OFS_HOLD: next_rdata = 32'h0000_0000;
            `OFS_FALL_OFF: next_rdata = 32'(fall_to_shutdown_delay);
            `OFS_STATUS: begin
                next_rdata[`ST_ENABLE_BIT] = en_level;
                next_rdata[`ST_IFACE_BIT] = tx_iface_en;
                next_rdata[`ST_PWR_BIT] = analog_power_en;
                next_rdata[`ST_READY_BIT] = analog_ready;
                next_rdata[`ST_ANT_BIT] = antenna_tx_sel;
                next_rdata[`ST_STATE_LSB +: 3] = state;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (clk_en) begin
            wb_ack_o <= bus_req;
            if (bus_req) begin
                wb_dat_o <= next_rdata;
            end
        end
    end

    a_iface_follows_fall: assert property (@(posedge core_clk) disable iff (reset)
        clk_en && en_fall |=> !tx_iface_en)
        else $error("interface still on after enable fall");
    a_iface_on_rise: assert property (@(posedge core_clk) disable iff (reset)
        clk_en && en_rise && !en_fall |=> tx_iface_en)
        else $error("interface not on after enable rise");
    a_power_after_delay: assert property (@(posedge core_clk) disable iff (reset)
        clk_en && pwr_done |=> analog_power_en)
        else $error("power not raised at rise-to-power count");
    a_antenna_on_delay: assert property (@(posedge core_clk) disable iff (reset)
        clk_en && ant_done && ant_owned |=> antenna_tx_sel)
        else $error("antenna not switched at count");
    a_antenna_before_pwr: assert property (@(posedge core_clk) disable iff (reset)
        $fell(analog_power_en) |-> !antenna_tx_sel && !$past(antenna_tx_sel))
        else $error("power dropped while antenna on transmit");
    a_iface_before_pwr: assert property (@(posedge core_clk) disable iff (reset)
        $fell(analog_power_en) |-> !tx_iface_en && !$past(tx_iface_en))
        else $error("power dropped before interface off");
    a_power_down_fall: assert property (@(posedge core_clk) disable iff (reset)
        clk_en && off_done && !en_level |=> !antenna_tx_sel ##1 !analog_power_en)
        else $error("shutdown not done at fall count");
    a_setup_ready: assert property (@(posedge core_clk) disable iff (reset)
        clk_en && setup_done |=> analog_ready)
        else $error("ready not flagged after setup");
    a_zero_delay_ant: assert property (@(posedge core_clk) disable iff (reset)
        clk_en && en_rise && rise_to_antenna_delay == '0 && ant_owned |=> antenna_tx_sel)
        else $error("zero antenna delay not immediate");

    c_burst_on: cover property (@(posedge core_clk) disable iff (reset)
        state == seq_rising ##1 state == seq_on);
    c_burst_end: cover property (@(posedge core_clk) disable iff (reset)
        state == seq_falling ##1 state == seq_idle);
    c_abort_rise: cover property (@(posedge core_clk) disable iff (reset)
        state == seq_rising && en_fall);
endmodule
